// ==== hdl/ndm_pkg.sv ====
// Operation
// (R1) set status bit 8 when receive process enters stopped state
// (R2) host-owned receive descriptor sets bit 7, suspends until frame or poll
// (R3) receive frame written and status stored sets bit 6, keep fetching
// (R4) transmit underrun sets bit 5, suspends transmit, flags descriptor word 0 bit 1
// (R5) jabber expiry while active sets bit 3, stops transmit, flags word 0 bit 14
// (R6) host-owned transmit descriptor sets bit 2, suspends until poll or auto-poll
// (R7) set status bit 1 when transmit process enters stopped state
// (R8) frame sent with status written sets bit 0, continue fetching
// (R9) mode bit 30 accepts all frames, match still reported in rx word 0 bit 30
// (R10) mode bit 29 keeps receive fifo when no buffer available
// (R11) mode bit 22, default one, selects 10 Mb/s threshold table
// (R12) mode bit 21 starts transmit only with whole frame in fifo
// (R13) mode bit 20 starts transmit at 16 bytes, overriding threshold settings
// (R14) mode bit 18, default one, selects external mii versus serial phy
// (R15) mode bit 16 holds at most one packet in transmit fifo
// (R16) threshold codes 00/01/10 give 128/256/512 or 72/96/128 bytes; 11 reserved
// (R17) normal summary from bits 0,2,6; abnormal summary from other enabled flags
package ndm_pkg;
  // ****************
  // register map
  // ****************
  localparam logic [11:0] ADDR_STATUS = 12'h028;
  localparam logic [11:0] ADDR_MODE = 12'h030;
  localparam logic [11:0] ADDR_MASK = 12'h038;
  // ****************
  // status fields
  // ****************
  localparam int ST_TX_COMPLETE = 0;
  localparam int ST_TX_STOPPED = 1;
  localparam int ST_TX_NO_BUF = 2;
  localparam int ST_TX_JABBER = 3;
  localparam int ST_TX_UNDERRUN = 5;
  localparam int ST_RX_COMPLETE = 6;
  localparam int ST_RX_NO_BUF = 7;
  localparam int ST_RX_STOPPED = 8;
  localparam int ST_ABNORMAL = 15;
  localparam int ST_NORMAL = 16;
  localparam logic [8:0] NORMAL_MASK = 9'h045;
  localparam logic [8:0] ABNORMAL_MASK = 9'h1aa;
  // ****************
  // mode fields
  // ****************
  localparam int MD_SINGLE_PKT = 16;
  localparam int MD_EXT_MII = 18;
  localparam int MD_START_MIN = 20;
  localparam int MD_STORE_FWD = 21;
  localparam int MD_SPEED_SEL = 22;
  localparam int MD_FIXED_ONE = 25;
  localparam int MD_KEEP_FIFO = 29;
  localparam int MD_ACCEPT_ALL = 30;
  localparam int TH_LO = 14;
  localparam logic [31:0] MODE_WMASK = 32'h6075c000;
  localparam logic [31:0] MODE_RESET = 32'h02440000;
  // ****************
  // thresholds in bytes, descriptor word 0 flag bit positions
  // ****************
  localparam logic [9:0] TH100_0 = 10'd128;
  localparam logic [9:0] TH100_1 = 10'd256;
  localparam logic [9:0] TH100_2 = 10'd512;
  localparam logic [9:0] TH10_0 = 10'd72;
  localparam logic [9:0] TH10_1 = 10'd96;
  localparam logic [9:0] TH10_2 = 10'd128;
  localparam logic [9:0] TH_MIN = 10'd16;
  localparam int TX_DESCRIPTOR_WORD0_UNDERRUN = 1;
  localparam int TX_DESCRIPTOR_WORD0_JABBER = 14;
  localparam int RX_DESCRIPTOR_WORD0_MATCH = 30;
endpackage

// ==== hdl/ndm_regs.sv ====
`timescale 1ns/1ps
module ndm_regs
  import ndm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // engine events, one-cycle pulses
  input wire logic ev_rx_stopped,
  input wire logic ev_rx_no_buf,
  input wire logic ev_rx_complete,
  input wire logic ev_tx_underrun,
  input wire logic ev_tx_jabber,
  input wire logic ev_tx_no_buf,
  input wire logic ev_tx_stopped,
  input wire logic ev_tx_complete,
  input wire logic rx_addr_match,
  // engine state
  input wire logic rx_frame_arrived,
  input wire logic rx_poll,
  input wire logic tx_poll,
  input wire logic tx_autopoll_timeout,
  input wire logic tx_active,
  input wire logic [10:0] tx_fifo_level,
  input wire logic tx_frame_in_fifo,
  input wire logic [3:0] tx_pkts_in_fifo,
  // controls to engines
  output logic rx_suspended,
  output logic tx_suspended,
  output logic tx_stop_req,
  output logic tx_start,
  output logic tx_fifo_accept_pkt,
  output logic rx_accept_all,
  output logic rx_keep_fifo,
  output logic phy_ext_mii,
  output logic [31:0] tx_desc_word0_flags,
  output logic [31:0] rx_desc_word0_flags
);
  logic [8:0] status_r;
  logic [8:0] status_nxt;
  logic [8:0] mask_r;
  logic [31:0] mode_r;
  logic [8:0] ev;
  logic [9:0] thresh;
  logic rd_access;
  logic wr_access;
  logic hit;

  // ****************
  // bus decode
  // ****************
  assign rd_access = psel && penable && !pwrite;
  assign wr_access = psel && penable && pwrite;
  assign hit = (paddr == ADDR_STATUS) || (paddr == ADDR_MODE) || (paddr == ADDR_MASK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ADDR_STATUS: begin
            prdata <= {15'h0, |(status_r & NORMAL_MASK & mask_r),
              |(status_r & ABNORMAL_MASK & mask_r), 6'h0, status_r}; // [R17]
          end
          ADDR_MODE: prdata <= mode_r;
          ADDR_MASK: prdata <= {23'h0, mask_r};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ****************
  // status flags
  // ****************
  assign ev[ST_RX_STOPPED] = ev_rx_stopped; // [R1]
  assign ev[ST_RX_NO_BUF] = ev_rx_no_buf; // [R2]
  assign ev[ST_RX_COMPLETE] = ev_rx_complete; // [R3]
  assign ev[ST_TX_UNDERRUN] = ev_tx_underrun; // [R4]
  assign ev[4] = 1'b0;
  assign ev[ST_TX_JABBER] = ev_tx_jabber && tx_active; // [R5]
  assign ev[ST_TX_NO_BUF] = ev_tx_no_buf; // [R6]
  assign ev[ST_TX_STOPPED] = ev_tx_stopped || (ev_tx_jabber && tx_active); // [R7]
  assign ev[ST_TX_COMPLETE] = ev_tx_complete; // [R8]

  always_comb begin
    status_nxt = status_r;
    if (pready && rd_access && paddr == ADDR_STATUS) begin
      status_nxt = 9'h0;
    end
    status_nxt = status_nxt | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 9'h0;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= 9'h0;
    end else if (pready && wr_access && paddr == ADDR_MASK) begin
      mask_r <= pwdata[8:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_nxt & mask_r);
    end
  end

  // ****************
  // mode register
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_RESET; // [R11] [R14]
    end else if (pready && wr_access && paddr == ADDR_MODE) begin
      mode_r <= (pwdata & MODE_WMASK) | (32'h1 << MD_FIXED_ONE);
    end
  end

  // ****************
  // process suspension
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_suspended <= 1'b0;
    end else if (ev_rx_no_buf) begin
      rx_suspended <= 1'b1; // [R2]
    end else if (rx_frame_arrived || rx_poll || ev_rx_complete) begin
      rx_suspended <= 1'b0; // [R3]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_suspended <= 1'b0;
    end else if (ev_tx_no_buf || ev_tx_underrun) begin
      tx_suspended <= 1'b1; // [R4] [R6]
    end else if (tx_poll || tx_autopoll_timeout || ev_tx_complete) begin
      tx_suspended <= 1'b0; // [R8]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_stop_req <= 1'b0;
    end else begin
      tx_stop_req <= ev_tx_jabber && tx_active; // [R5]
    end
  end

  // ****************
  // descriptor flags
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_desc_word0_flags <= 32'h0;
      rx_desc_word0_flags <= 32'h0;
    end else begin
      tx_desc_word0_flags <= ({31'h0, ev_tx_underrun} << TX_DESCRIPTOR_WORD0_UNDERRUN) // [R4]
        | ({31'h0, ev_tx_jabber && tx_active} << TX_DESCRIPTOR_WORD0_JABBER); // [R5]
      rx_desc_word0_flags <= {31'h0, rx_addr_match} << RX_DESCRIPTOR_WORD0_MATCH; // [R9]
    end
  end

  // ****************
  // transmit start
  // ****************
  always_comb begin
    thresh = TH100_0;
    unique case ({mode_r[MD_SPEED_SEL], mode_r[TH_LO+1:TH_LO]}) // [R11] [R16]
      3'b000: thresh = TH100_0;
      3'b001: thresh = TH100_1;
      3'b010: thresh = TH100_2;
      3'b100: thresh = TH10_0;
      3'b101: thresh = TH10_1;
      3'b110: thresh = TH10_2;
      default: thresh = TH100_2;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_start <= 1'b0;
    end else if (mode_r[MD_START_MIN]) begin
      tx_start <= tx_fifo_level >= {1'b0, TH_MIN}; // [R13]
    end else if (mode_r[MD_STORE_FWD]) begin
      tx_start <= tx_frame_in_fifo; // [R12]
    end else begin
      tx_start <= tx_fifo_level > {1'b0, thresh};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_fifo_accept_pkt <= 1'b1;
      rx_accept_all <= 1'b0;
      rx_keep_fifo <= 1'b0;
      phy_ext_mii <= 1'b1;
    end else begin
      tx_fifo_accept_pkt <= !mode_r[MD_SINGLE_PKT] || tx_pkts_in_fifo == 4'h0; // [R15]
      rx_accept_all <= mode_r[MD_ACCEPT_ALL]; // [R9]
      rx_keep_fifo <= mode_r[MD_KEEP_FIFO]; // [R10]
      phy_ext_mii <= mode_r[MD_EXT_MII]; // [R14]
    end
  end
endmodule // ndm_regs

// ==== test/ndm_regs_sva.sv ====
`timescale 1ns/1ps
module ndm_regs_sva
  import ndm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic ev_tx_underrun,
  input wire logic ev_tx_jabber,
  input wire logic ev_tx_no_buf,
  input wire logic ev_rx_no_buf,
  input wire logic tx_active,
  input wire logic tx_stop_req,
  input wire logic rx_addr_match,
  input wire logic rx_frame_arrived,
  input wire logic tx_poll,
  input wire logic rx_suspended,
  input wire logic tx_suspended,
  input wire logic [31:0] tx_desc_word0_flags,
  input wire logic [31:0] rx_desc_word0_flags
);
  // ****************
  // checks
  // ****************
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  rdy_wait_a: assert property (psel && !penable |=> pready)
    else $error("ready late");
  err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error data");
  under_flag_a: assert property (
    ev_tx_underrun |=> tx_desc_word0_flags[TX_DESCRIPTOR_WORD0_UNDERRUN] && tx_suspended)
    else $error("underrun");
  jab_stop_a: assert property (
    ev_tx_jabber && tx_active |=> tx_stop_req && tx_desc_word0_flags[TX_DESCRIPTOR_WORD0_JABBER])
    else $error("jabber");
  jab_idle_a: assert property (
    !(ev_tx_jabber && tx_active) |=> !tx_stop_req && !tx_desc_word0_flags[TX_DESCRIPTOR_WORD0_JABBER])
    else $error("jabber while idle");
  match_pass_a: assert property (
    1 |=> rx_desc_word0_flags[RX_DESCRIPTOR_WORD0_MATCH] == $past(rx_addr_match))
    else $error("match");
  rx_susp_a: assert property (ev_rx_no_buf |=> rx_suspended)
    else $error("rx suspend");
  rx_resume_a: assert property (
    rx_suspended && rx_frame_arrived && !ev_rx_no_buf |=> !rx_suspended)
    else $error("rx resume");
  tx_susp_a: assert property (ev_tx_no_buf |=> tx_suspended)
    else $error("tx suspend");
  tx_resume_a: assert property (
    tx_suspended && tx_poll && !ev_tx_no_buf && !ev_tx_underrun |=> !tx_suspended)
    else $error("tx resume");
  cover property (ev_tx_jabber && tx_active);
  cover property (pready && pslverr);
  cover property (rx_suspended && rx_frame_arrived);
endmodule // ndm_regs_sva
bind ndm_regs ndm_regs_sva chk (.*);

// ==== test/ndm_regs_test.sv ====
`timescale 1ns/1ps
module ndm_regs_test;
  import ndm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, mt, act, fr, e;
  logic pready, pslverr, irq, rs, ts, stp, st, acc, aa, kf, em;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, x, txf, rxf;
  logic [12:0] p;
  logic [10:0] lvl;
  logic [3:0] np;
  int errors, check_count;
  int th[6] = '{128, 256, 512, 72, 96, 128};
  ndm_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .ev_tx_complete(p[0]), .ev_tx_stopped(p[1]),
    .ev_tx_no_buf(p[2]), .ev_tx_jabber(p[3]), .ev_tx_underrun(p[5]), .ev_rx_complete(p[6]),
    .ev_rx_no_buf(p[7]), .ev_rx_stopped(p[8]), .rx_frame_arrived(p[9]), .rx_poll(p[10]),
    .tx_poll(p[11]), .tx_autopoll_timeout(p[12]), .rx_addr_match(mt), .tx_active(act),
    .tx_fifo_level(lvl), .tx_frame_in_fifo(fr), .tx_pkts_in_fifo(np), .rx_suspended(rs),
    .tx_suspended(ts), .tx_stop_req(stp), .tx_start(st), .tx_fifo_accept_pkt(acc),
    .rx_accept_all(aa), .rx_keep_fifo(kf), .phy_ext_mii(em), .tx_desc_word0_flags(txf),
    .rx_desc_word0_flags(rxf));
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  // ****************
  // helpers
  // ****************
  task chk(input logic [31:0] g, input logic [31:0] v);
    check_count++;
    if (g !== v) begin
      errors++;
      $display("unexpected %0t got %h want %h", $time, g, v);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task pulse(input int b);
    @(posedge pclk);
    p[b] <= 1;
    @(posedge pclk);
    p[b] <= 0;
    @(negedge pclk);
  endtask
  task lv(input logic [10:0] l, input logic f, input logic v);
    @(posedge pclk);
    lvl <= l;
    fr <= f;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk(st, v);
  endtask
  // ****************
  // tests
  // ****************
  task t_regs;
    chk({em, acc}, 2'b11);
    apb(0, ADDR_MODE, 0);
    chk(q, MODE_RESET);
    apb(1, ADDR_MODE, '1);
    apb(0, ADDR_MODE, 0);
    chk(q, MODE_WMASK | 32'h02000000);
    @(negedge pclk);
    chk({aa, kf, em}, 3'b111);
    apb(1, ADDR_MODE, 0);
    repeat (2) @(negedge pclk);
    chk({aa, kf, em}, 3'b000);
    apb(0, 12'h3fc, 0);
    chk(e, 1);
    chk(q, 0);
    mt <= 1;
    repeat (2) @(negedge pclk);
    chk(rxf[RX_DESCRIPTOR_WORD0_MATCH], 1);
    $display("regs done");
  endtask
  task t_ev;
    apb(1, ADDR_MASK, 32'h1ff);
    act <= 1;
    for (int b = 0; b < 9; b++) begin
      if (b == 4) continue;
      x = (32'h1 << b) | (b == 3 ? 32'h2 : 32'h0);
      x = x | {|(x[8:0] & NORMAL_MASK), |(x[8:0] & ABNORMAL_MASK), 15'h0};
      pulse(b);
      chk(irq, 1);
      apb(0, ADDR_STATUS, 0);
      chk(q, x);
      apb(0, ADDR_STATUS, 0);
      @(negedge pclk);
      chk(q, 0);
      chk(irq, 0);
    end
    apb(1, ADDR_MASK, 0);
    act <= 0;
    pulse(0);
    pulse(3);
    chk(irq, 0);
    apb(0, ADDR_STATUS, 0);
    chk(q, 1);
    $display("events done");
  endtask
  task t_susp;
    for (int i = 0; i < 4; i++) begin
      pulse(i < 2 ? 7 : 2);
      chk(i < 2 ? rs : ts, 1);
      pulse(9 + i);
      chk(i < 2 ? rs : ts, 0);
    end
    $display("suspend done");
  endtask
  task t_tx;
    for (int c = 0; c < 6; c++) begin
      apb(1, ADDR_MODE, 32'((c / 3) << MD_SPEED_SEL | (c % 3) << TH_LO));
      lv(11'(th[c]), 0, 0);
      lv(11'(th[c] + 1), 0, 1);
    end
    apb(1, ADDR_MODE, 32'h1 << MD_START_MIN);
    lv(15, 0, 0);
    lv(16, 0, 1);
    apb(1, ADDR_MODE, 32'h1 << MD_STORE_FWD);
    lv(15, 1, 1);
    lv(200, 0, 0);
    apb(1, ADDR_MODE, 32'h1 << MD_SINGLE_PKT);
    np <= 1;
    repeat (2) @(negedge pclk);
    chk(acc, 0);
    $display("transmit done");
  endtask
  task test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, mt, act, fr, p, lvl, np, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_ev();
    t_susp();
    t_tx();
    test_done();
  end
  initial begin
    #100000;
    errors++;
    test_done();
  end
endmodule // ndm_regs_test
